// [hw/ssc_host.sv]
`timescale 1ns/1ps
`include "ssc_params.svh"
module ssc_host #(
    parameter int PERIPH_CLK_NS = 42,
    parameter int DOUT_NS = 50,
    parameter int SETUP_NS = 50,
    parameter logic [15:0] POLL_MAX = `SSC_POLL_MAX
) (
    // clocking
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    // software port
    input wire logic [3:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [7:0] bus_rdata,
    output logic irq,
    // device register port
    output ssc_pkg::ssc_dreg_t dreg,
    input wire logic [7:0] dreg_rdata,
    // serial link
    output logic sclk,
    output logic host_txd,
    input wire logic dev_txd
);
    localparam int CLK_NS = `SSC_CLK_NS;
    localparam int START_I = (`SSC_START_PERIPH_CLKS * PERIPH_CLK_NS + DOUT_NS + SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int LAST_HIGH_I = (`SSC_LAST_HIGH_PERIPH_CLKS * PERIPH_CLK_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0] START_CYC = 8'(START_I);
    localparam logic [7:0] LAST_HIGH = 8'(LAST_HIGH_I);

    ssc_pkg::ssc_state_t state_r;
    ssc_pkg::ssc_cmd_t cmd_r;
    ssc_pkg::ssc_dreg_t dreg_r;
    logic [2:0] step_r;
    logic [7:0] cnt_r;
    logic [15:0] poll_r;
    logic [2:0] bit_r;
    logic [3:0] frames_r;
    logic [3:0] cfg_frames_r;
    logic cfg_late_r;
    logic cfg_f32_r;
    logic [7:0] half_r;
    logic [7:0] word_r;
    logic [7:0] htx_r;
    logic [7:0] shift_r;
    logic [7:0] rx_r;
    logic [2:0] stat_r;
    logic [2:0] en_r;
    logic irq_r;
    logic [7:0] rdata_r;
    logic sclk_r;
    logic txd_r;
    logic dev_bit;

    // device data pin comes from the far clock domain
    ssc_sync3 u_sync (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .ce(ce),
        .d(dev_txd),
        .q(dev_bit)
    );

    // fixed device programming sequences, one op per step
    function automatic ssc_pkg::ssc_op_t op_rom(input ssc_pkg::ssc_cmd_t c, input logic [2:0] s, input logic f32);
        ssc_pkg::ssc_op_t o;
        o = '{kind: ssc_pkg::OP_END, addr: 8'h00, data: 8'h00, mask: 8'h00};
        if (c == ssc_pkg::CMD_SNOOZE)
        begin
            case (s)
                3'h0:
                begin
                    o.kind = ssc_pkg::OP_WR;
                    o.addr = `SSC_D_EXT_MODE;
                    o.data[`SSC_F_BITRATE_MOD_EN] = 1'b1;
                end
                3'h1: o = '{kind: ssc_pkg::OP_WR, addr: `SSC_D_SERIAL_MODE, data: `SSC_PRESCALE_9600, mask: 8'h00};
                3'h2: o = '{kind: ssc_pkg::OP_WR, addr: `SSC_D_BIT_RATE, data: f32 ? `SSC_RATE_32 : `SSC_RATE_24,
                            mask: 8'h00};
                3'h3: o = '{kind: ssc_pkg::OP_WR, addr: `SSC_D_MOD_DUTY, data: f32 ? `SSC_DUTY_32 : `SSC_DUTY_24,
                            mask: 8'h00};
                default: o.kind = ssc_pkg::OP_END;
            endcase
        end
        else if (c == ssc_pkg::CMD_COND_CLR)
        begin
            case (s)
                3'h0: o = '{kind: ssc_pkg::OP_WR, addr: `SSC_D_I2C_MODE3, data: 8'h00, mask: 8'h00};
                3'h1: o = '{kind: ssc_pkg::OP_POLL, addr: `SSC_D_I2C_MODE3, data: 8'h00,
                            mask: 8'h01 << `SSC_F_COND_DONE};
                default: o.kind = ssc_pkg::OP_END;
            endcase
        end
        else if (c == ssc_pkg::CMD_SWITCH)
        begin
            case (s)
                3'h0: o = '{kind: ssc_pkg::OP_POLL, addr: `SSC_D_FIFO_STATUS, data: 8'h01 << `SSC_F_RX_END,
                            mask: 8'h01 << `SSC_F_RX_END};
                3'h1: o = '{kind: ssc_pkg::OP_WR, addr: `SSC_D_SERIAL_CTRL, data: 8'h00, mask: 8'h00};
                3'h2: o = '{kind: ssc_pkg::OP_POLL, addr: `SSC_D_FIFO_STATUS, data: 8'h00,
                            mask: 8'h01 << `SSC_F_OVERRUN};
                3'h3: o = '{kind: ssc_pkg::OP_WR, addr: `SSC_D_SERIAL_CTRL,
                            data: (8'h01 << `SSC_F_TX_IRQ_EN) | (8'h01 << `SSC_F_RX_IRQ_EN)
                                | (8'h01 << `SSC_F_TX_EN) | (8'h01 << `SSC_F_RX_EN), mask: 8'h00};
                default: o.kind = ssc_pkg::OP_END;
            endcase
        end
        return o;
    endfunction

    // decode and selection
    ssc_pkg::ssc_op_t cur_op;
    ssc_pkg::ssc_dreg_t word_wr;
    assign cur_op = op_rom(cmd_r, step_r, cfg_f32_r);
    assign word_wr = '{wr: 1'b1, rd: 1'b0, addr: `SSC_D_TX_DATA, wdata: word_r};
    wire idle = state_r == ssc_pkg::ST_IDLE;
    wire cmd_go = bus_wr && bus_addr == `SSC_A_CMD && idle;
    wire cfg_wr = bus_wr && bus_addr == `SSC_A_CFG && idle;
    wire half_wr = bus_wr && bus_addr == `SSC_A_HALF && idle;
    wire cnt_zero = cnt_r == 8'h00;
    wire last_bit = bit_r == 3'h7;
    wire more = frames_r != 4'h0;
    wire [2:0] nbit = bit_r + 3'h1;
    wire poll_ok = (dreg_rdata & cur_op.mask) == cur_op.data;
    // late update stretches the bit 7 high phase so the device can reload
    wire stretch = last_bit && cfg_late_r && half_r < LAST_HIGH - 8'h01;
    wire [7:0] hi_load = stretch ? LAST_HIGH - 8'h01 : half_r;
    wire ev_frame = state_r == ssc_pkg::ST_HIGH && cnt_zero && last_bit;
    wire ev_seq = state_r == ssc_pkg::ST_OP && cur_op.kind == ssc_pkg::OP_END;
    wire ev_tmo = state_r == ssc_pkg::ST_CHK && !poll_ok && poll_r == POLL_MAX;
    wire [2:0] ev_set = {ev_tmo, ev_seq, ev_frame};
    wire [2:0] ev_clr = (bus_wr && bus_addr == `SSC_A_IRQ_CLR) ? bus_wdata[2:0] : 3'h0;
    wire [2:0] stat_nxt = (stat_r & ~ev_clr) | ev_set;
    wire [7:0] rd_mux =
        (bus_addr == `SSC_A_CFG) ? {2'h0, cfg_f32_r, cfg_late_r, cfg_frames_r} :
        (bus_addr == `SSC_A_HALF) ? half_r :
        (bus_addr == `SSC_A_WORD) ? word_r :
        (bus_addr == `SSC_A_HOST_TX) ? htx_r :
        (bus_addr == `SSC_A_RX) ? rx_r :
        (bus_addr == `SSC_A_IRQ_STAT) ? {5'h00, stat_r} :
        (bus_addr == `SSC_A_IRQ_EN) ? {5'h00, en_r} :
        (bus_addr == `SSC_A_STATUS) ? {!idle, 1'b0, cmd_r, frames_r} : 8'h00;

    // software registers, interrupt and read port; a set beats a clear
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            {cfg_f32_r, cfg_late_r, cfg_frames_r} <= `SSC_CFG_RST;
            half_r <= `SSC_HALF_RST;
            word_r <= 8'h00;
            htx_r <= 8'h00;
            en_r <= 3'h0;
            stat_r <= 3'h0;
            irq_r <= 1'b0;
            rdata_r <= 8'h00;
        end
        else if (ce)
        begin
            if (cfg_wr)
                {cfg_f32_r, cfg_late_r, cfg_frames_r} <= bus_wdata[5:0];
            if (half_wr)
                half_r <= bus_wdata;
            if (bus_wr && bus_addr == `SSC_A_WORD)
                word_r <= bus_wdata;
            if (bus_wr && bus_addr == `SSC_A_HOST_TX)
                htx_r <= bus_wdata;
            if (bus_wr && bus_addr == `SSC_A_IRQ_EN)
                en_r <= bus_wdata[2:0];
            stat_r <= stat_nxt;
            irq_r <= |(stat_nxt & en_r);
            rdata_r <= bus_rd ? rd_mux : 8'h00;
        end
    end

    // sequencer and link engine; the sync clock idles high
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            state_r <= ssc_pkg::ST_IDLE;
            cmd_r <= ssc_pkg::CMD_XFER;
            dreg_r <= '{wr: 1'b0, rd: 1'b0, addr: 8'h00, wdata: 8'h00};
            step_r <= 3'h0;
            cnt_r <= 8'h00;
            poll_r <= 16'h0000;
            bit_r <= 3'h0;
            frames_r <= 4'h0;
            shift_r <= 8'h00;
            rx_r <= 8'h00;
            sclk_r <= 1'b1;
            txd_r <= 1'b1;
        end
        else if (ce)
        begin
            dreg_r.wr <= 1'b0;
            dreg_r.rd <= 1'b0;
            case (state_r)
                ssc_pkg::ST_IDLE:
                begin
                    if (cmd_go)
                    begin
                        cmd_r <= ssc_pkg::ssc_cmd_t'(bus_wdata[1:0]);
                        step_r <= 3'h0;
                        poll_r <= 16'h0000;
                        frames_r <= cfg_frames_r;
                        state_r <= (bus_wdata[1:0] == 2'b00) ? ssc_pkg::ST_WORD : ssc_pkg::ST_OP;
                    end
                end
                ssc_pkg::ST_OP:
                begin
                    if (cur_op.kind == ssc_pkg::OP_WR)
                    begin
                        dreg_r <= '{wr: 1'b1, rd: 1'b0, addr: cur_op.addr, wdata: cur_op.data};
                        step_r <= step_r + 3'h1;
                    end
                    else if (cur_op.kind == ssc_pkg::OP_POLL)
                    begin
                        dreg_r <= '{wr: 1'b0, rd: 1'b1, addr: cur_op.addr, wdata: 8'h00};
                        state_r <= ssc_pkg::ST_RWAIT;
                    end
                    else
                        state_r <= ssc_pkg::ST_IDLE;
                end
                ssc_pkg::ST_RWAIT: state_r <= ssc_pkg::ST_CHK;
                ssc_pkg::ST_CHK:
                begin
                    // read back until the field matches, with a bound on tries
                    if (poll_ok)
                    begin
                        step_r <= step_r + 3'h1;
                        poll_r <= 16'h0000;
                        state_r <= ssc_pkg::ST_OP;
                    end
                    else if (poll_r == POLL_MAX)
                        state_r <= ssc_pkg::ST_IDLE;
                    else
                    begin
                        poll_r <= poll_r + 16'h0001;
                        state_r <= ssc_pkg::ST_OP;
                    end
                end
                ssc_pkg::ST_WORD:
                begin
                    dreg_r <= word_wr;
                    // count from the cycle the device takes the word, not the one that launches it
                    cnt_r <= START_CYC;
                    state_r <= ssc_pkg::ST_WAIT;
                end
                ssc_pkg::ST_WAIT:
                begin
                    if (cnt_zero)
                    begin
                        sclk_r <= 1'b0;
                        txd_r <= htx_r[0];
                        bit_r <= 3'h0;
                        cnt_r <= half_r;
                        state_r <= ssc_pkg::ST_LOW;
                    end
                    else
                        cnt_r <= cnt_r - 8'h01;
                end
                ssc_pkg::ST_LOW:
                begin
                    if (cnt_zero)
                    begin
                        sclk_r <= 1'b1;
                        cnt_r <= hi_load;
                        state_r <= ssc_pkg::ST_HIGH;
                        if (bit_r == 3'h6 && more && !cfg_late_r)
                            dreg_r <= word_wr;
                    end
                    else
                        cnt_r <= cnt_r - 8'h01;
                end
                ssc_pkg::ST_HIGH:
                begin
                    if (cnt_zero)
                    begin
                        shift_r <= {dev_bit, shift_r[7:1]};
                        if (last_bit)
                            rx_r <= {dev_bit, shift_r[7:1]};
                        if (last_bit && !more)
                            state_r <= ssc_pkg::ST_IDLE;
                        else
                        begin
                            sclk_r <= 1'b0;
                            txd_r <= htx_r[nbit];
                            bit_r <= nbit;
                            cnt_r <= half_r;
                            state_r <= ssc_pkg::ST_LOW;
                            if (last_bit)
                                frames_r <= frames_r - 4'h1;
                            if (bit_r == 3'h6 && more && cfg_late_r)
                                dreg_r <= word_wr;
                        end
                    end
                    else
                        cnt_r <= cnt_r - 8'h01;
                end
                default: state_r <= ssc_pkg::ST_IDLE;
            endcase
        end
    end

    assign bus_rdata = rdata_r;
    assign irq = irq_r;
    assign dreg = dreg_r;
    assign sclk = sclk_r;
    assign host_txd = txd_r;

    // helpers read only by the checks below
    logic [7:0] since_wr_r;
    logic [7:0] hi_len_r;
    logic rx_end_seen_r;
    wire word_out = dreg_r.wr && dreg_r.addr == `SSC_D_TX_DATA;
    wire ctrl_out = dreg_r.wr && dreg_r.addr == `SSC_D_SERIAL_CTRL;
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            since_wr_r <= 8'h00;
            hi_len_r <= 8'h00;
            rx_end_seen_r <= 1'b0;
        end
        else if (ce)
        begin
            since_wr_r <= word_out ? 8'h01 : (since_wr_r == 8'hff ? since_wr_r : since_wr_r + 8'h01);
            hi_len_r <= !sclk_r ? 8'h00 : (hi_len_r == 8'hff ? hi_len_r : hi_len_r + 8'h01);
            if (cmd_go)
                rx_end_seen_r <= 1'b0;
            else if (state_r == ssc_pkg::ST_CHK && poll_ok && cur_op.mask[`SSC_F_RX_END])
                rx_end_seen_r <= 1'b1;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    sequence s_cond_write;
        dreg_r.wr && dreg_r.addr == `SSC_D_I2C_MODE3 && dreg_r.wdata[`SSC_F_COND_DONE] == 1'b0;
    endsequence
    sequence s_cond_read;
        dreg_r.rd && dreg_r.addr == `SSC_D_I2C_MODE3;
    endsequence
    sequence s_rate24;
        dreg_r.wr && dreg_r.addr == `SSC_D_BIT_RATE && dreg_r.wdata == `SSC_RATE_24;
    endsequence

    AST_START_GAP: assert property (ce && state_r == ssc_pkg::ST_WAIT && cnt_zero |=> !sclk_r && since_wr_r > START_CYC)
        else $error("sync clock started too soon after the data write");
    AST_EARLY_WORD: assert property (word_out && !cfg_late_r && state_r != ssc_pkg::ST_WAIT |-> sclk_r && bit_r == 3'h6)
        else $error("next word not written before bit 7 falling edge");
    AST_LATE_WORD: assert property (word_out && cfg_late_r && state_r != ssc_pkg::ST_WAIT |-> !sclk_r && last_bit)
        else $error("late word written outside the clock low phase");
    AST_LAST_HIGH: assert property (state_r == ssc_pkg::ST_HIGH && last_bit && cfg_late_r && cnt_zero |-> hi_len_r >= LAST_HIGH - 8'h01)
        else $error("bit 7 high phase shorter than four peripheral clocks");
    AST_SNOOZE_ZERO: assert property (dreg_r.wr && dreg_r.addr == `SSC_D_EXT_MODE |-> dreg_r.wdata[`SSC_F_DBL_SPEED] == 1'b0 && dreg_r.wdata[`SSC_F_ASYNC_BASE] == 1'b0 && dreg_r.wdata[`SSC_F_ASYNC_BASE_EXT] == 1'b0)
        else $error("snooze clock selects not zero");
    AST_RATE_24: assert property (dreg_r.wr && dreg_r.addr == `SSC_D_BIT_RATE && !cfg_f32_r && ce |-> s_rate24 ##1 dreg_r.wr && dreg_r.addr == `SSC_D_MOD_DUTY && dreg_r.wdata == `SSC_DUTY_24)
        else $error("24 MHz rate or duty value wrong");
    AST_RATE_32: assert property (dreg_r.wr && dreg_r.addr == `SSC_D_MOD_DUTY && cfg_f32_r |-> dreg_r.wdata == `SSC_DUTY_32 && $past(dreg_r.wdata) == `SSC_RATE_32)
        else $error("32 MHz rate or duty value wrong");
    AST_COND_READBACK: assert property (s_cond_write and ce |-> ##[1:3] s_cond_read)
        else $error("condition flag not read back after clearing");
    AST_SWITCH_CLEAR: assert property (ctrl_out && !dreg_r.wdata[`SSC_F_TX_EN] |-> rx_end_seen_r && dreg_r.wdata[`SSC_F_RX_EN] == 1'b0 && dreg_r.wdata[`SSC_F_RX_IRQ_EN] == 1'b0)
        else $error("receive enables cleared before reception end");
    AST_SWITCH_ALL: assert property (ctrl_out && dreg_r.wdata[`SSC_F_TX_EN] |-> dreg_r.wdata[`SSC_F_TX_IRQ_EN] && dreg_r.wdata[`SSC_F_RX_IRQ_EN] && dreg_r.wdata[`SSC_F_RX_EN] && rx_end_seen_r)
        else $error("enables not set together in one write");
endmodule

// [common/ssc_params.svh]
`ifndef SSC_PARAMS_SVH
`define SSC_PARAMS_SVH

// timing
`define SSC_CLK_NS 10
`define SSC_START_PERIPH_CLKS 1
`define SSC_LAST_HIGH_PERIPH_CLKS 4
`define SSC_POLL_MAX 16'h0400

// host register addresses
`define SSC_A_CMD 4'h0
`define SSC_A_CFG 4'h1
`define SSC_A_HALF 4'h2
`define SSC_A_WORD 4'h3
`define SSC_A_HOST_TX 4'h4
`define SSC_A_RX 4'h5
`define SSC_A_IRQ_STAT 4'h6
`define SSC_A_IRQ_CLR 4'h7
`define SSC_A_IRQ_EN 4'h8
`define SSC_A_STATUS 4'h9

// host register reset values
`define SSC_HALF_RST 8'h05
`define SSC_CFG_RST 6'h00

// interrupt status bits
`define SSC_I_FRAME 0
`define SSC_I_SEQ 1
`define SSC_I_TIMEOUT 2

// device register addresses
`define SSC_D_SERIAL_MODE 8'h00
`define SSC_D_BIT_RATE 8'h01
`define SSC_D_SERIAL_CTRL 8'h02
`define SSC_D_TX_DATA 8'h03
`define SSC_D_FIFO_STATUS 8'h04
`define SSC_D_EXT_MODE 8'h07
`define SSC_D_I2C_MODE3 8'h0f
`define SSC_D_MOD_DUTY 8'h12

// device field positions
`define SSC_F_TX_IRQ_EN 7
`define SSC_F_RX_IRQ_EN 6
`define SSC_F_TX_EN 5
`define SSC_F_RX_EN 4
`define SSC_F_DBL_SPEED 6
`define SSC_F_ASYNC_BASE 4
`define SSC_F_ASYNC_BASE_EXT 3
`define SSC_F_BITRATE_MOD_EN 2
`define SSC_F_COND_DONE 3
`define SSC_F_OVERRUN 5
`define SSC_F_RX_END 1

// snooze rate values
`define SSC_PRESCALE_9600 8'h00
`define SSC_RATE_24 8'h3d
`define SSC_DUTY_24 8'hce
`define SSC_RATE_32 8'h3e
`define SSC_DUTY_32 8'h9d
`endif

// [common/ssc_pkg.sv]
package ssc_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_OP = 3'b001,
        ST_RWAIT = 3'b010,
        ST_CHK = 3'b011,
        ST_WORD = 3'b100,
        ST_WAIT = 3'b101,
        ST_LOW = 3'b110,
        ST_HIGH = 3'b111
    } ssc_state_t;

    typedef enum logic [1:0] {
        CMD_XFER = 2'b00,
        CMD_SNOOZE = 2'b01,
        CMD_COND_CLR = 2'b10,
        CMD_SWITCH = 2'b11
    } ssc_cmd_t;

    typedef enum logic [1:0] {
        OP_WR = 2'b00,
        OP_POLL = 2'b01,
        OP_END = 2'b10
    } ssc_kind_t;

    typedef struct packed {
        ssc_kind_t kind;
        logic [7:0] addr;
        logic [7:0] data;
        logic [7:0] mask;
    } ssc_op_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ssc_dreg_t;
endpackage

// [hw/ssc_sync3.sv]
`timescale 1ns/1ps
// three-stage pin synchroniser; output moves only when stages two and three agree
module ssc_sync3 (
    // clocking
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    // pin in, clean level out
    input wire logic d,
    output logic q
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic q_r;

    // idle line level is high, so reset to high to avoid a false bit
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            s1_r <= 1'b1;
            s2_r <= 1'b1;
            s3_r <= 1'b1;
            q_r <= 1'b1;
        end
        else if (ce)
        begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r)
                q_r <= s3_r;
        end
    end

    assign q = q_r;
endmodule

// [testbench/ssc_dev_model.sv]
`timescale 1ns/1ps
// device side: register file, flags that settle only after a few polls, sync shifter
module ssc_dev_model #(
    parameter int START_MIN = 15,
    parameter int LAST_MIN = 17
) (
    // clocking
    input wire logic clk_sys,
    input wire logic rstn,
    // register port
    input wire ssc_pkg::ssc_dreg_t dreg,
    output logic [7:0] dreg_rdata,
    // serial link
    input wire logic sclk,
    input wire logic host_txd,
    output logic dev_txd,
    // bench side
    input wire logic stuck,
    output logic [7:0] rx_byte,
    output logic [7:0] viol
);
    logic [7:0] regs [0:31];
    logic [7:0] tx_sh;
    logic [7:0] rx_sh;
    logic [7:0] viol_a;
    logic [7:0] viol_b;
    logic [2:0] bitn;
    logic [1:0] slow;
    logic sclk_q;
    logic fresh;
    logic late;
    logic armed;
    int since_wr;
    int hi_len;
    wire fall = sclk_q & ~sclk;
    wire rise = ~sclk_q & sclk;
    wire [4:0] a = dreg.addr[4:0];
    wire tx_wr = dreg.wr && a == 5'h03;
    assign viol = viol_a + viol_b;

    // register port; read data stands one cycle, then turns over so it is never held
    always @(posedge clk_sys)
    begin
        dreg_rdata <= dreg.rd ? regs[a] : ~dreg_rdata;
        if (!rstn)
        begin
            for (int i = 0; i < 32; i++)
                regs[i] <= 8'h00;
            regs[15] <= 8'h08;
            regs[4] <= 8'h22;
            {slow, armed, viol_a} <= '0;
        end
        else if (dreg.wr)
        begin
            regs[a] <= (a == 5'h0f) ? (dreg.wdata | 8'h08) : dreg.wdata;
            slow <= 2'd0;
            if (a == 5'h02 && dreg.wdata == 8'h00)
                armed <= 1'b1;
            if (a == 5'h02 && dreg.wdata == 8'hf0 && (!armed || regs[4][5]))
                viol_a <= viol_a + 8'h01;
        end
        else if (dreg.rd && (a == 5'h0f || a == 5'h04))
        begin
            slow <= slow + 2'd1;
            if (slow == 2'd2 && !stuck)
                regs[a][a == 5'h0f ? 3 : 5] <= 1'b0;
        end
    end

    // shift on the host clock edges, reload the word at each frame start
    always @(posedge clk_sys)
    begin
        sclk_q <= sclk;
        hi_len <= sclk ? hi_len + 1 : 0;
        since_wr <= tx_wr ? 0 : since_wr + 1;
        if (!rstn)
        begin
            {bitn, late, fresh, viol_b, rx_byte} <= '0;
            dev_txd <= 1'b1;
        end
        else
        begin
            if (fall)
            begin
                {tx_sh, dev_txd} <= (bitn == 3'd0) ? {1'b0, regs[3]} : {1'b0, tx_sh};
                late <= 1'b0;
                if ((bitn == 3'd0 && fresh && since_wr < START_MIN) || (late && hi_len < LAST_MIN))
                    viol_b <= viol_b + 8'h01;
            end
            // a late word lands on the bit 7 fall itself, so it must win over the clear above
            if (tx_wr)
            begin
                fresh <= (bitn == 3'd0);
                late <= (bitn == 3'd7);
                if (bitn == 3'd7 && sclk)
                    viol_b <= viol_b + 8'h01;
            end
            if (rise)
            begin
                rx_sh <= {host_txd, rx_sh[7:1]};
                bitn <= bitn + 3'd1;
                if (bitn == 3'd7)
                    rx_byte <= {host_txd, rx_sh[7:1]};
            end
        end
    end
endmodule

// [testbench/serial_sync_transfer_constraints_tb.sv]
`timescale 1ns/1ps
module serial_sync_transfer_constraints_tb;
    logic clk_sys;
    logic rstn;
    logic bus_wr;
    logic bus_rd;
    logic stuck;
    logic irq;
    logic sclk;
    logic host_txd;
    logic dev_txd;
    logic [3:0] bus_addr;
    logic [7:0] bus_wdata;
    logic [7:0] bus_rdata;
    logic [7:0] rd_val;
    logic [7:0] dev_rx;
    logic [7:0] viol;
    logic [7:0] dreg_rdata;
    ssc_pkg::ssc_dreg_t dreg;
    int fail_count;
    int checks;

    // 100 MHz system clock
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    ssc_host #(.POLL_MAX(16'h0010)) dut (.clk_sys(clk_sys), .rstn(rstn), .ce(1'b1), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .irq(irq),
        .dreg(dreg), .dreg_rdata(dreg_rdata), .sclk(sclk), .host_txd(host_txd), .dev_txd(dev_txd));
    ssc_dev_model model (.clk_sys(clk_sys), .rstn(rstn), .dreg(dreg), .dreg_rdata(dreg_rdata), .sclk(sclk),
        .host_txd(host_txd), .dev_txd(dev_txd), .stuck(stuck), .rx_byte(dev_rx), .viol(viol));

    task chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
            fail_count++;
        end
    endtask

    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk_sys);
        bus_wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task rd(input logic [3:0] a);
        @(posedge clk_sys);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk_sys);
        bus_rd <= 1'b0;
        #1;
        rd_val = bus_rdata;
    endtask

    // clear status, start a command, try a refused write, poll busy, leave interrupt status in rd_val
    task run(input logic [7:0] cmd);
        wr(4'h7, 8'h07);
        wr(4'h0, cmd);
        wr(4'h2, 8'h07);
        rd(4'h9);
        for (int i = 0; i < 300 && rd_val[7] !== 1'b0; i++)
            rd(4'h9);
        chk(rd_val & 8'h80, 8'h00);
        rd(4'h6);
    endtask

    task print_verdict;
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // cycle ceiling against a hang
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        chk(8'h00, 8'h01);
        print_verdict();
    end

    initial
    begin
        {rstn, bus_wr, bus_rd, stuck, bus_addr, bus_wdata} = '0;
        fail_count = 0;
        checks = 0;
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
        rd(4'h2);
        chk(rd_val, 8'h05);
        rd(4'hf);
        chk(rd_val, 8'h00);
        wr(4'h2, 8'h02);
        wr(4'h3, 8'ha5);
        wr(4'h4, 8'h3c);
        wr(4'h8, 8'h01);
        // two frames back to back, early then late word update
        for (int m = 0; m < 2; m++)
        begin
            wr(4'h1, m ? 8'h11 : 8'h01);
            run(8'h00);
            chk(rd_val & 8'h01, 8'h01);
            chk({7'h0, irq}, 8'h01);
            rd(4'h5);
            chk(rd_val, 8'ha5);
            chk(dev_rx, 8'h3c);
            chk(viol, 8'h00);
        end
        wr(4'h1, 8'h00);
        run(8'h01);
        chk(model.regs[7], 8'h04);
        chk(model.regs[0], 8'h00);
        chk(model.regs[1], 8'h3d);
        chk(model.regs[18], 8'hce);
        wr(4'h1, 8'h20);
        run(8'h01);
        chk(model.regs[1], 8'h3e);
        chk(model.regs[18], 8'h9d);
        // sequence done is masked: only frame events enabled
        run(8'h02);
        chk(rd_val, 8'h02);
        chk(model.regs[15], 8'h00);
        chk({7'h0, irq}, 8'h00);
        run(8'h03);
        chk(rd_val, 8'h02);
        chk(model.regs[2], 8'hf0);
        chk(viol, 8'h00);
        // flag never clears: poll limit must end the sequence
        stuck <= 1'b1;
        wr(4'h8, 8'h04);
        run(8'h02);
        chk(rd_val & 8'h04, 8'h04);
        chk({7'h0, irq}, 8'h01);
        wr(4'h7, 8'h07);
        repeat (2) @(posedge clk_sys);
        #1;
        chk({7'h0, irq}, 8'h00);
        rd(4'h2);
        chk(rd_val, 8'h02);
        print_verdict();
    end
endmodule
